//--- hw/output_fault_response.sv
/*
  Output overvoltage / undervoltage fault response for one channel: settings
  registers, supervisor sample tick, channel enable state machine, status and
  host alert.
  Assumes fault flags come from supervisor comparators on core_clk and that
  settings are written through a command decoder as strobe plus data.
*/
`timescale 1ns/1ps
module output_fault_response #(
  parameter logic [ofr_pkg::RETRY_W-1:0] RETRY_SAMPLES =
    ofr_pkg::RETRY_W'(ofr_pkg::RETRY_SAMPLES_DEFAULT)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ov_detect,
  input wire logic uv_detect,
  input wire logic odd_channel_current_mode,
  input wire logic channel_on_cmd,
  input wire logic fault_clear,
  input wire logic ov_reaction_we,
  input wire ofr_pkg::setting_t ov_reaction_wdata,
  input wire logic uv_reaction_we,
  input wire ofr_pkg::setting_t uv_reaction_wdata,
  output ofr_pkg::setting_t ov_reaction_rdata,
  output ofr_pkg::setting_t uv_reaction_rdata,
  output logic channel_enable,
  output logic host_alert_line_n,
  output logic status_vout_ov,
  output logic status_vout_uv,
  output logic status_byte_vout_ov,
  output logic status_word_vout
);
  import ofr_pkg::*;

  typedef struct packed {
    setting_t ov_reaction;
    setting_t uv_reaction;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    chan_state_t state;
    retry_t ov_retry;
    retry_t uv_retry;
    logic [RETRY_W-1:0] retry_cnt;
    logic enable;
    logic ov_stat;
    logic uv_stat;
    logic byte_ov;
    logic word_vout;
    logic alert_n;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    ov_reaction: REACTION_RESET,
    uv_reaction: REACTION_RESET,
    tick_cnt: '0,
    tick: 1'b0,
    state: CH_OFF,
    ov_retry: RETRY_NONE,
    uv_retry: RETRY_NONE,
    retry_cnt: '0,
    enable: 1'b0,
    ov_stat: 1'b0,
    uv_stat: 1'b0,
    byte_ov: 1'b0,
    word_vout: 1'b0,
    alert_n: 1'b1
  };

  top_state_t s_ff;
  top_state_t nxt_s;
  logic ov_f;
  logic uv_f;
  logic shut_any;
  retry_t shut_retry;

  fault_eval_if ov_if();
  fault_eval_if uv_if();

  ////////////////////////////////////////////////////////////////////////////
  // fault masking and evaluators

  // current-mode odd channels have no voltage limits to compare against
  assign ov_f = ov_detect & ~odd_channel_current_mode;
  assign uv_f = uv_detect & ~odd_channel_current_mode;

  assign ov_if.fault = ov_f;
  assign ov_if.tick = s_ff.tick;
  assign ov_if.setting = s_ff.ov_reaction;
  assign uv_if.fault = uv_f;
  assign uv_if.tick = s_ff.tick;
  assign uv_if.setting = s_ff.uv_reaction;

  fault_deglitch ov_eval (
    .core_clk(core_clk),
    .rst(rst),
    .ev(ov_if.eval)
  );

  fault_deglitch uv_eval (
    .core_clk(core_clk),
    .rst(rst),
    .ev(uv_if.eval)
  );

  assign shut_any = ov_if.shutdown_req | uv_if.shutdown_req;
  // overvoltage takes precedence when both trip together
  assign shut_retry = ov_if.shutdown_req ? s_ff.ov_retry : s_ff.uv_retry;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_s = s_ff;

    nxt_s.tick = 1'b0;
    if (s_ff.tick_cnt == TICK_LAST) begin
      nxt_s.tick_cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + TICK_W'(1);
    end

    if (ov_reaction_we) begin
      nxt_s.ov_reaction = ov_reaction_wdata;
    end
    if (uv_reaction_we) begin
      nxt_s.uv_reaction = uv_reaction_wdata;
    end

    // a new fault in the clearing cycle survives the clear
    if (fault_clear) begin
      nxt_s.ov_stat = 1'b0;
      nxt_s.uv_stat = 1'b0;
    end
    if (ov_f) begin
      nxt_s.ov_stat = 1'b1;
    end
    if (uv_f) begin
      nxt_s.uv_stat = 1'b1;
    end
    nxt_s.byte_ov = nxt_s.ov_stat;
    nxt_s.word_vout = nxt_s.ov_stat | nxt_s.uv_stat;
    nxt_s.alert_n = ~(nxt_s.ov_stat | nxt_s.uv_stat);

    unique case (s_ff.state)
      CH_OFF: begin
        if (channel_on_cmd) begin
          nxt_s.state = CH_RUN;
          // retry changes only land on the next off-then-on
          nxt_s.ov_retry = get_retry(s_ff.ov_reaction);
          nxt_s.uv_retry = get_retry(s_ff.uv_reaction);
        end
      end
      CH_RUN: begin
        if (!channel_on_cmd) begin
          nxt_s.state = CH_OFF;
        end else if (shut_any) begin
          nxt_s.retry_cnt = '0;
          if (shut_retry == RETRY_NONE) begin
            nxt_s.state = CH_FAULT_OFF;
          end else begin
            nxt_s.state = CH_RETRY_WAIT;
          end
        end
      end
      CH_FAULT_OFF: begin
        if (fault_clear) begin
          nxt_s.state = CH_OFF;
        end
      end
      CH_RETRY_WAIT: begin
        if (!channel_on_cmd) begin
          nxt_s.state = CH_OFF;
        end else if (s_ff.tick) begin
          if (s_ff.retry_cnt == RETRY_SAMPLES - RETRY_W'(1)) begin
            nxt_s.state = CH_RUN;
          end else begin
            nxt_s.retry_cnt = s_ff.retry_cnt + RETRY_W'(1);
          end
        end
      end
    endcase

    nxt_s.enable = (nxt_s.state == CH_RUN);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_ff <= TOP_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign ov_reaction_rdata = s_ff.ov_reaction;
  assign uv_reaction_rdata = s_ff.uv_reaction;
  assign channel_enable = s_ff.enable;
  assign host_alert_line_n = s_ff.alert_n;
  assign status_vout_ov = s_ff.ov_stat;
  assign status_vout_uv = s_ff.uv_stat;
  assign status_byte_vout_ov = s_ff.byte_ov;
  assign status_word_vout = s_ff.word_vout;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SETTING_STORED: assert property (@(posedge core_clk) disable iff (rst)
    ov_reaction_we |=> ov_reaction_rdata == $past(ov_reaction_wdata))
    else $error("overvoltage setting not stored");

  AST_STATUS_SET: assert property (@(posedge core_clk) disable iff (rst)
    (ov_detect && !odd_channel_current_mode) |=>
      (status_vout_ov && status_byte_vout_ov && status_word_vout))
    else $error("overvoltage status bits not set");

  AST_ALERT_LOW: assert property (@(posedge core_clk) disable iff (rst)
    ((ov_detect || uv_detect) && !odd_channel_current_mode) |=> !host_alert_line_n)
    else $error("host alert not pulled low on fault");

  AST_ODD_CHANNEL_SILENT: assert property (@(posedge core_clk) disable iff (rst)
    (odd_channel_current_mode && !status_vout_uv) |=> !status_vout_uv)
    else $error("current-mode channel flagged undervoltage");

  AST_LATCHED_OFF: assert property (@(posedge core_clk) disable iff (rst)
    (s_ff.state == CH_FAULT_OFF && !fault_clear) |=> !channel_enable [*2])
    else $error("channel restarted with retry disabled");

  AST_RETRY_ENTERED: assert property (@(posedge core_clk) disable iff (rst)
    (s_ff.state == CH_RUN && channel_on_cmd && shut_any && shut_retry != RETRY_NONE)
      |=> (s_ff.state == CH_RETRY_WAIT && !channel_enable))
    else $error("retry wait not entered after shutdown");

endmodule // output_fault_response

//--- hw/ofr_pkg.sv
/*
  Constants, field layout, channel states and field helpers for the output
  fault response block.
  Assumes a single 40 MHz core clock and supervisor fault flags on that clock.
*/
// How it works
// - setting: action 7:6, retry 5:3, delay 2:0
// - action 00 keeps channel running
// - action 01 shuts down after deglitch delay
// - action 1X shuts down at once
// - retry 000 stays off until cleared
// - nonzero retry restarts endlessly at interval
// - retry setting taken at channel turn-on
// - zero delay turns off at first detection
// - delay N waits N supervisor samples
// - fault sets status word, vout bits; status byte bit on overvoltage only
// - fault pulls host alert line low
// - odd current-mode channel ignores faults
package ofr_pkg;

  localparam int ACTION_MSB = 7;
  localparam int ACTION_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  typedef logic [1:0] action_t;
  typedef logic [2:0] retry_t;
  typedef logic [2:0] delay_t;
  typedef logic [7:0] setting_t;

  localparam action_t ACTION_IGNORE = 2'h0;
  localparam action_t ACTION_DELAYED = 2'h1;
  localparam int ACTION_NOW_BIT = 1;
  localparam retry_t RETRY_NONE = 3'h0;
  localparam delay_t DELAY_NONE = 3'h0;
  localparam setting_t REACTION_RESET = 8'h00;

  // supervisor sample period, nominal
  localparam real SAMPLE_PERIOD_US = 12.2;
  localparam real CLK_FREQ_MHZ = 40.0;
  localparam int SAMPLE_CYCLES = int'(SAMPLE_PERIOD_US * CLK_FREQ_MHZ);
  localparam int TICK_W = 9;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);

  // restart interval in supervisor samples, plain default
  localparam int RETRY_W = 8;
  localparam int RETRY_SAMPLES_DEFAULT = 8;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_RUN = 2'b01,
    CH_FAULT_OFF = 2'b11,
    CH_RETRY_WAIT = 2'b10
  } chan_state_t;

  function automatic action_t get_action(input setting_t s);
    return s[ACTION_MSB:ACTION_LSB];
  endfunction

  function automatic retry_t get_retry(input setting_t s);
    return s[RETRY_MSB:RETRY_LSB];
  endfunction

  function automatic delay_t get_delay(input setting_t s);
    return s[DELAY_MSB:DELAY_LSB];
  endfunction

endpackage

//--- hw/fault_eval_if.sv
/*
  Carrier between the channel controller and one fault deglitch evaluator.
  Assumes all signals live on core_clk.
*/
`timescale 1ns/1ps
interface fault_eval_if;
  logic fault;
  logic tick;
  logic [7:0] setting;
  logic shutdown_req;

  modport eval (input fault, input tick, input setting, output shutdown_req);
  modport user (output fault, output tick, output setting, input shutdown_req);
endinterface

//--- hw/fault_deglitch.sv
/*
  Deglitch and action decode for one fault kind (overvoltage or undervoltage).
  Assumes fault is already masked and sampled on core_clk, tick is one cycle.
*/
`timescale 1ns/1ps
module fault_deglitch
  import ofr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  fault_eval_if.eval ev
);

  typedef struct packed {
    delay_t cnt;
    logic shut;
  } dg_state_t;

  dg_state_t s_ff;
  dg_state_t nxt_s;
  action_t act;
  delay_t dly;

  assign act = get_action(ev.setting);
  assign dly = get_delay(ev.setting);
  assign ev.shutdown_req = s_ff.shut;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.shut = 1'b0;
    if (!ev.fault) begin
      nxt_s.cnt = DELAY_NONE;
    end else if (act[ACTION_NOW_BIT]) begin
      nxt_s.shut = 1'b1;
    end else if (act == ACTION_DELAYED) begin
      if (s_ff.cnt >= dly) begin
        nxt_s.shut = 1'b1;
      end else if (ev.tick) begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
      end
    end else begin
      nxt_s.cnt = DELAY_NONE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  AST_IGNORE_KEEPS_RUNNING: assert property (@(posedge core_clk) disable iff (rst)
    (act == ACTION_IGNORE) |=> !ev.shutdown_req)
    else $error("ignore action produced a shutdown");

  AST_IMMEDIATE_SHUTDOWN: assert property (@(posedge core_clk) disable iff (rst)
    (ev.fault && act[ACTION_NOW_BIT]) |=> ev.shutdown_req)
    else $error("immediate action did not shut down");

  AST_ZERO_DELAY: assert property (@(posedge core_clk) disable iff (rst)
    (ev.fault && act == ACTION_DELAYED && dly == DELAY_NONE) |=> ev.shutdown_req)
    else $error("zero deglitch delay did not shut down at once");

  AST_DEGLITCH_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (act == ACTION_DELAYED && s_ff.cnt < dly) |=> !ev.shutdown_req)
    else $error("shutdown before deglitch count reached");

  AST_FAULT_GONE_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    !ev.fault |=> (s_ff.cnt == DELAY_NONE && !ev.shutdown_req))
    else $error("pending count kept after fault vanished");

endmodule // fault_deglitch

//--- bench/converter_model.sv
/*
  Behavioural supervised converter: reports output OV/UV comparator flags.
  Assumes the bench sets the wanted fault conditions off the clock edge.
*/
`timescale 1ns/1ps
module converter_model (
  input wire logic channel_enable,
  input wire logic ov_force,
  input wire logic uv_force,
  output logic ov_detect,
  output logic uv_detect
);
  assign ov_detect = ov_force;
  // a disabled converter has no output to sag, so no undervoltage trip
  assign uv_detect = uv_force & channel_enable;
endmodule // converter_model

//--- bench/output_fault_response_bench.sv
/*
  Self-checking bench for the output fault response block.
  Assumes the package constants and a 40 MHz core clock; restart interval set to 1 sample.
*/
`timescale 1ns/1ps
module output_fault_response_bench;
  import ofr_pkg::*;
  logic core_clk, rst, ov_force, uv_force, odd_mode, on_cmd, clr;
  logic ov_we, uv_we, ov_det, uv_det, en, alert_n, s_ov, s_uv, sb_ov, sw_v;
  logic seen;
  setting_t ov_wd, uv_wd, ov_rd, uv_rd;
  setting_t imm [3] = '{8'h80, 8'hC0, 8'h40};
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  output_fault_response #(.RETRY_SAMPLES(8'h01)) dut (
    .core_clk(core_clk), .rst(rst), .ov_detect(ov_det), .uv_detect(uv_det),
    .odd_channel_current_mode(odd_mode), .channel_on_cmd(on_cmd), .fault_clear(clr),
    .ov_reaction_we(ov_we), .ov_reaction_wdata(ov_wd), .uv_reaction_we(uv_we),
    .uv_reaction_wdata(uv_wd), .ov_reaction_rdata(ov_rd), .uv_reaction_rdata(uv_rd),
    .channel_enable(en), .host_alert_line_n(alert_n), .status_vout_ov(s_ov),
    .status_vout_uv(s_uv), .status_byte_vout_ov(sb_ov), .status_word_vout(sw_v)
  );
  converter_model conv (
    .channel_enable(en), .ov_force(ov_force), .uv_force(uv_force),
    .ov_detect(ov_det), .uv_detect(uv_det)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // whole run is under 10k cycles; twice that means a hang
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input setting_t got, input setting_t exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t setting got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input setting_t ov_s, input setting_t uv_s);
    ov_we = 1'b1;
    ov_wd = ov_s;
    uv_we = 1'b1;
    uv_wd = uv_s;
    cyc(1);
    ov_we = 1'b0;
    uv_we = 1'b0;
    chk_byte(ov_rd, ov_s);
    chk_byte(uv_rd, uv_s);
  endtask

  task automatic wait_en(input logic exp, input int lim);
    int i;
    for (i = 0; i < lim && en !== exp; i++) @(negedge core_clk);
    chk_bit(en, exp);
  endtask

  // off, clear latched state and status, program, then turn on
  task automatic start(input setting_t ov_s, input setting_t uv_s);
    on_cmd = 1'b0;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    wr(ov_s, uv_s);
    on_cmd = 1'b1;
    wait_en(1'b1, 3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, ov_force, uv_force, odd_mode, on_cmd, clr, ov_we, uv_we} = 8'h80;
    ov_wd = 8'h00;
    uv_wd = 8'h00;
    seen = 1'b0;
    // four rising edges under reset, released on a falling edge
    cyc(4);
    chk_bit(en, 1'b0);
    chk_bit(alert_n, 1'b1);
    chk_byte(ov_rd, REACTION_RESET);
    chk_byte(uv_rd, REACTION_RESET);
    rst = 1'b0;
    // ignore action: keeps running, status and alert still raised
    start(8'h00, 8'h00);
    ov_force = 1'b1;
    cyc(5);
    chk_bit(en, 1'b1);
    chk_bit(s_ov, 1'b1);
    chk_bit(sb_ov, 1'b1);
    chk_bit(sw_v, 1'b1);
    chk_bit(alert_n, 1'b0);
    ov_force = 1'b0;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    chk_bit(alert_n, 1'b1);
    // immediate and zero-delay shutdown, no retry; later retry write deferred
    foreach (imm[k]) begin
      start(imm[k], imm[k]);
      wr(imm[k] | 8'h08, 8'h00);
      ov_force = 1'b1;
      cyc(1);
      ov_force = 1'b0;
      wait_en(1'b0, 3);
      cyc(1000);
      chk_bit(en, 1'b0);
    end
    // delayed shutdown, three samples; 976 cycles hold exactly two ticks
    start(8'h00, 8'h43);
    uv_force = 1'b1;
    cyc(976);
    chk_bit(en, 1'b1);
    uv_force = 1'b0;
    cyc(1);
    uv_force = 1'b1;
    // a count kept over the glitch would reach three in here
    cyc(976);
    chk_bit(en, 1'b1);
    wait_en(1'b0, 600);
    chk_bit(s_uv, 1'b1);
    chk_bit(s_ov, 1'b0);
    chk_bit(sw_v, 1'b1);
    uv_force = 1'b0;
    // endless restart, then commanded off while waiting to restart
    start(8'hC8, 8'h00);
    repeat (2) begin
      ov_force = 1'b1;
      cyc(1);
      ov_force = 1'b0;
      wait_en(1'b0, 3);
      wait_en(1'b1, 600);
    end
    ov_force = 1'b1;
    cyc(1);
    ov_force = 1'b0;
    wait_en(1'b0, 3);
    on_cmd = 1'b0;
    wait_en(1'b0, 3);
    // longer than one restart interval: any restart would show here
    repeat (1000) begin
      @(negedge core_clk);
      seen |= en;
    end
    chk_bit(seen, 1'b0);
    // odd channel in current mode ignores everything
    start(8'h80, 8'h80);
    odd_mode = 1'b1;
    ov_force = 1'b1;
    uv_force = 1'b1;
    cyc(5);
    chk_bit(en, 1'b1);
    chk_bit(alert_n, 1'b1);
    chk_bit(s_ov, 1'b0);
    complete_run();
  end
endmodule // output_fault_response_bench
